// [include/stsc_defines.vh]
`ifndef STSC_DEFINES_VH
`define STSC_DEFINES_VH

// trigger source codes
`define STSC_SRC_W 3
`define STSC_SRC_BUS 3'h0
`define STSC_SRC_BACKPLANE 3'h1
`define STSC_SRC_EXT 3'h2
`define STSC_SRC_HOLD 3'h3
`define STSC_SRC_IMM 3'h4

// reset defaults
`define STSC_RST_SRC 3'h4
`define STSC_RST_ARM_COUNT 8'h01
`define STSC_RST_CONT 1'h0

// self-test answers
`define STSC_TST_PASS 8'h00
`define STSC_TST_MFR 8'h67
`define STSC_TST_PON 8'h6E

// query keyword codes
`define STSC_KW_BUS 3'h0
`define STSC_KW_BACKPLANE_TRIGGER_SOURCE 3'h1
`define STSC_KW_EXT 3'h2
`define STSC_KW_HOLD 3'h3
`define STSC_KW_IMM 3'h4

// channel list
`define STSC_CH_W 4
`define STSC_CH_LAST 4'hF

// settle delay counter width
`define STSC_SETTLE_W 16

// switchboxes sharing the external trigger input
`define STSC_NBOX 4
`define STSC_BOX_W 2

`endif

// [rtl/stsc_scan_trigger.v]
`timescale 1ns/1ps
`include "stsc_defines.vh"

// Function
// - source select is stored; armed only by initiate
// - immediate trigger only in hold or bus
// - software trigger leaves source selection unchanged
// - backplane source: falling strobe advances channel
// - after advance wait settle, flag settled
// - external input owned by first requesting box
// - owner keeps input until source changes
// - request while owned elsewhere: refuse, flag error
// - bus source accepts three trigger origins
// - reset command restores defaults (box 0 slot only), opens channels
// - source query returns keyword code
// - self-test returns 110, 103 or 0
// - clear-status clears all held status
// - abort stops scan, returns idle
module stsc_scan_trigger (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_b_i,
  // command strobes, one cycle each
  input wire set_src_i,
  input wire [`STSC_SRC_W-1:0] src_sel_i,
  input wire [`STSC_BOX_W-1:0] box_sel_i,
  input wire define_list_i,
  input wire [`STSC_CH_W-1:0] list_first_i,
  input wire [`STSC_CH_W-1:0] list_last_i,
  input wire initiate_i,
  input wire soft_trig_i,
  input wire common_trig_i,
  input wire group_exec_trig_i,
  input wire abort_i,
  input wire reset_cmd_i,
  input wire clear_status_i,
  input wire [`STSC_SETTLE_W-1:0] route_settle_delay_i,
  input wire [7:0] arm_count_i,
  input wire set_arm_count_i,
  input wire set_cont_i,
  input wire cont_i,
  // self-test inputs
  input wire power_on_intr_i,
  input wire id_bad_i,
  // trigger lines
  input wire scan_step_b_i,
  input wire event_in_i,
  // outputs
  output reg [`STSC_SRC_W-1:0] src_query_o,
  output reg [7:0] self_test_o,
  output reg armed_o,
  output reg list_valid_o,
  output reg [`STSC_CH_W-1:0] channel_o,
  output reg channel_closed_o,
  output reg route_settled_b_o,
  output reg error_o,
  output reg [`STSC_NBOX-1:0] ext_owner_o,
  output reg [7:0] arm_count_o,
  output reg cont_o
);

  localparam ST_IDLE = 3'b001;
  localparam ST_ARMED = 3'b010;
  localparam ST_SETTLE = 3'b100;

  reg [2:0] state;
  reg [`STSC_CH_W-1:0] first_ch;
  reg [`STSC_CH_W-1:0] last_ch;
  reg [`STSC_SETTLE_W-1:0] settle_cnt;
  reg trig;
  wire [`STSC_SRC_W*`STSC_NBOX-1:0] box_src;
  wire [`STSC_NBOX-1:0] box_own;
  wire [`STSC_SRC_W-1:0] cur_src;
  wire step_fall;
  wire ext_rise;
  wire ext_free;
  wire ext_mine;
  wire ext_req;
  wire src_refused;
  wire src_load;
  genvar g;

  // only box 0 drives this block's scan; other boxes share the ext arbiter
  assign cur_src = box_src[`STSC_SRC_W-1:0];
  assign ext_free = ~|ext_owner_o;
  assign ext_mine = ext_owner_o[box_sel_i];
  assign ext_req = set_src_i && (src_sel_i == `STSC_SRC_EXT);
  // a claim on an input held by another box stores no source; it only sets error_o
  assign src_refused = ext_req && !ext_free && !ext_mine;
  // selection only stores; soft triggers never touch it
  assign src_load = set_src_i && !src_refused;

  // owners are flip-flops inside the slots; this only gathers them
  always @* begin
    ext_owner_o = box_own;
  end

  // one slot per switchbox: stored source and external-input ownership
  generate
    for (g = 0; g < `STSC_NBOX; g = g + 1) begin : box_gen
      stsc_box_slot stsc_box_slot_i (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .load_i(src_load && (box_sel_i == g)),
        .src_sel_i(src_sel_i),
        .claim_i(ext_req),
        .restore_i(reset_cmd_i && (g == 0)),
        .src_o(box_src[g*`STSC_SRC_W +: `STSC_SRC_W]),
        .own_o(box_own[g])
      );
    end
  endgenerate

  // detectors start at the idle level of their pin, so reset gives no edge
  stsc_edge_det #(
    .IDLE(1'b1),
    .FALL(1'b1)
  ) stsc_edge_det_step_i (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .pin_i(scan_step_b_i),
    .edge_o(step_fall)
  );

  stsc_edge_det #(
    .IDLE(1'b0),
    .FALL(1'b0)
  ) stsc_edge_det_ext_i (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .pin_i(event_in_i),
    .edge_o(ext_rise)
  );

  // trigger from the selected source
  always @* begin
    trig = 1'b0;
    case (cur_src)
      `STSC_SRC_BUS: trig = soft_trig_i | common_trig_i | group_exec_trig_i;
      `STSC_SRC_HOLD: trig = soft_trig_i;
      `STSC_SRC_BACKPLANE: trig = step_fall;
      `STSC_SRC_EXT: trig = ext_owner_o[0] & ext_rise;
      `STSC_SRC_IMM: trig = 1'b1;
      default: trig = 1'b0;
    endcase
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_IDLE;
      first_ch <= {`STSC_CH_W{1'b0}};
      last_ch <= {`STSC_CH_W{1'b0}};
      settle_cnt <= {`STSC_SETTLE_W{1'b0}};
      armed_o <= 1'b0;
      list_valid_o <= 1'b0;
      channel_o <= {`STSC_CH_W{1'b0}};
      channel_closed_o <= 1'b0;
      route_settled_b_o <= 1'b1;
      error_o <= 1'b0;
      arm_count_o <= `STSC_RST_ARM_COUNT;
      cont_o <= `STSC_RST_CONT;
    end else begin
      route_settled_b_o <= 1'b1;
      if (set_arm_count_i) begin
        arm_count_o <= arm_count_i;
      end
      if (set_cont_i) begin
        cont_o <= cont_i;
      end
      if (define_list_i) begin
        first_ch <= list_first_i;
        last_ch <= list_last_i;
        list_valid_o <= 1'b1;
      end
      // error level stays until clear-status; a new error wins over clear
      if (src_refused) begin
        error_o <= 1'b1;
      end else if (clear_status_i) begin
        error_o <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          if (initiate_i && (list_valid_o || define_list_i)) begin
            state <= ST_ARMED;
            armed_o <= 1'b1;
            channel_o <= define_list_i ? list_first_i : first_ch;
            channel_closed_o <= 1'b1;
          end
        end
        ST_ARMED: begin
          if (trig) begin
            channel_o <= (channel_o == last_ch) ? first_ch : channel_o + 1'b1;
            settle_cnt <= route_settle_delay_i;
            state <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (settle_cnt == {`STSC_SETTLE_W{1'b0}}) begin
            route_settled_b_o <= 1'b0;
            state <= ST_ARMED;
          end else begin
            settle_cnt <= settle_cnt - 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
      if (abort_i) begin
        state <= ST_IDLE;
        armed_o <= 1'b0;
      end
      if (reset_cmd_i) begin
        state <= ST_IDLE;
        armed_o <= 1'b0;
        list_valid_o <= 1'b0;
        channel_closed_o <= 1'b0;
        arm_count_o <= `STSC_RST_ARM_COUNT;
        cont_o <= `STSC_RST_CONT;
      end
    end
  end

  // query answers are registered copies of state
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      src_query_o <= `STSC_KW_IMM;
      self_test_o <= `STSC_TST_PASS;
    end else begin
      src_query_o <= cur_src;
      if (power_on_intr_i) begin
        self_test_o <= `STSC_TST_PON;
      end else if (id_bad_i) begin
        self_test_o <= `STSC_TST_MFR;
      end else begin
        self_test_o <= `STSC_TST_PASS;
      end
    end
  end

endmodule // stsc_scan_trigger

module stsc_box_slot (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_b_i,
  // commands for this box
  input wire load_i,
  input wire [`STSC_SRC_W-1:0] src_sel_i,
  input wire claim_i,
  input wire restore_i,
  // stored state
  output reg [`STSC_SRC_W-1:0] src_o,
  output reg own_o
);

  // a reset command wins over a source command in the same cycle
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      src_o <= `STSC_RST_SRC;
      own_o <= 1'b0;
    end else if (restore_i) begin
      src_o <= `STSC_RST_SRC;
      own_o <= 1'b0;
    end else if (load_i) begin
      src_o <= src_sel_i;
      if (claim_i) begin
        own_o <= 1'b1;
      end else begin
        own_o <= 1'b0;
      end
    end
  end

endmodule // stsc_box_slot

module stsc_edge_det #(
  parameter IDLE = 1'b1,
  parameter FALL = 1'b1
) (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_b_i,
  // sampled pin and its edge
  input wire pin_i,
  output wire edge_o
);

  reg prev;

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev <= IDLE;
    end else begin
      prev <= pin_i;
    end
  end

  // edge shows in the cycle the pin first carries its new level
  assign edge_o = FALL ? (prev & ~pin_i) : (~prev & pin_i);

endmodule // stsc_edge_det

// [testbench/stsc_far_model.sv]
`timescale 1ns/1ps
module stsc_far_model(
  input wire sys_clk_i,
  input wire fire_i,
  output reg step_b_o);
  // pulled-up line: low for one cycle after each cycle that fire is high
  initial step_b_o=1'b1;
  always @(posedge sys_clk_i) step_b_o<=!fire_i;
endmodule // stsc_far_model

// [testbench/stsc_scan_trigger_chk.sv]
`timescale 1ns/1ps
module stsc_scan_trigger_chk(
  input wire sys_clk_i,input wire rst_b_i,input wire abort_i,input wire reset_cmd_i,
  input wire clear_status_i,input wire power_on_intr_i,input wire armed_o,input wire route_settled_b_o,
  input wire error_o,input wire [2:0] src_query_o,input wire [7:0] self_test_o,input wire [7:0] arm_count_o,
  input wire [3:0] channel_o,input wire [3:0] ext_owner_o);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // three matches the settle delay the bench applies
  sequence settle_s; route_settled_b_o[*3] ##1 !route_settled_b_o; endsequence
  AST_SETTLE: assert property ($changed(channel_o)&&armed_o&&$past(armed_o) |=> settle_s)
    else $error("settle");
  AST_RST_CNT: assert property (reset_cmd_i |=> arm_count_o==8'h01)
    else $error("arm count");
  AST_RST_SRC: assert property (reset_cmd_i |=> ##1 src_query_o==3'h4)
    else $error("reset source");
  AST_ABORT: assert property (abort_i |=> !armed_o)
    else $error("abort");
  AST_TST: assert property (power_on_intr_i[*2] |=> self_test_o==8'h6E)
    else $error("self test");
  AST_OWN: assert property ($onehot0(ext_owner_o))
    else $error("owners");
  AST_ERR: assert property (error_o&&!clear_status_i |=> error_o)
    else $error("error lost");
  AST_CLS: assert property (clear_status_i |=> !error_o)
    else $error("error kept");
endmodule // stsc_scan_trigger_chk
bind stsc_scan_trigger stsc_scan_trigger_chk stsc_scan_trigger_chk_i(.sys_clk_i,.rst_b_i,.abort_i,.reset_cmd_i,
  .clear_status_i,.power_on_intr_i,.armed_o,.route_settled_b_o,.error_o,.src_query_o,.self_test_o,.arm_count_o,
  .channel_o,.ext_owner_o);

// [testbench/test_scan_trigger_source_control.sv]
`timescale 1ns/1ps
module test_scan_trigger_source_control;
  reg sys_clk_i=0;
  reg rst_b_i=0;
  reg [9:0] s=0;
  reg [2:0] sr=0;
  reg [1:0] bx=0;
  reg pw=0,bp=0;
  wire sb,er,ar,lv,cc,co;
  wire [2:0] q;
  wire [7:0] t,ac;
  wire [3:0] ch,own;
  integer err_total=0,samples_checked=0,n,b;
  always #4 sys_clk_i=~sys_clk_i;
  stsc_far_model stsc_far_model_i(.sys_clk_i(sys_clk_i),.fire_i(bp),.step_b_o(sb));
  stsc_scan_trigger stsc_scan_trigger_i(.sys_clk_i(sys_clk_i),.rst_b_i(rst_b_i),.set_src_i(s[0]),.src_sel_i(sr),
    .box_sel_i(bx),.define_list_i(s[1]),.list_first_i(4'h0),.list_last_i(4'hF),.initiate_i(s[2]),
    .soft_trig_i(s[3]),.common_trig_i(s[4]),.group_exec_trig_i(s[5]),.abort_i(s[6]),.reset_cmd_i(s[7]),
    .clear_status_i(s[8]),.route_settle_delay_i(16'h0003),.arm_count_i(8'h05),.set_arm_count_i(s[9]),
    .set_cont_i(s[9]),.cont_i(1'b1),.power_on_intr_i(pw),.id_bad_i(pw),.scan_step_b_i(sb),.event_in_i(bp),
    .src_query_o(q),.self_test_o(t),.armed_o(ar),.list_valid_o(lv),.channel_o(ch),.channel_closed_o(cc),
    .route_settled_b_o(),.error_o(er),.ext_owner_o(own),.arm_count_o(ac),.cont_o(co));
  task c(input integer m);
    repeat (m) @(posedge sys_clk_i);
    #1;
  endtask
  task go(input [9:0] v);
    s=v;
    c(1);
    s=0;
    c(1);
  endtask
  task so(input [2:0] v,input [1:0] x);
    sr=v;
    bx=x;
    go(10'h001);
  endtask
  task k(input [7:0] a,input [7:0] e);
    samples_checked++;
    if (a!==e) begin
      err_total++;
      $display("mismatch %0t got %h want %h",$time,a,e);
    end
  endtask
  // trigger, check channel, then let the settle pulse finish
  task tr(input [9:0] v,input [3:0] e);
    go(v);
    k(ch,e);
    c(4);
  endtask
  task end_of_test;
    $display("%0d checks %0d mismatches",samples_checked,err_total);
    if (err_total==0&&samples_checked>0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #20000;
    err_total++;
    end_of_test;
  end
  initial begin
    n=$urandom(32'h45C6);
    c(4);
    rst_b_i=1;
    for (n=0;n<5;n++) begin
      so(n[2:0],2'h0);
      k(q,n[7:0]);
    end
    so(3'h3,2'h0);
    go(10'h008);
    k(ch,8'h00);
    go(10'h002);
    go(10'h004);
    k(ar,8'h01);
    k(cc,8'h01);
    n=1+$urandom%4;
    for (b=1;b<=n;b++) tr(10'h008,b[3:0]);
    tr(10'h010,n[3:0]);
    k(q,8'h03);
    $display("hold test done");
    go(10'h040);
    k(ar,8'h00);
    so(3'h0,2'h0);
    go(10'h004);
    tr(10'h010,4'h1);
    tr(10'h020,4'h2);
    tr(10'h008,4'h3);
    go(10'h040);
    so(3'h1,2'h0);
    go(10'h004);
    bp=1;
    c(1);
    bp=0;
    c(3);
    k(ch,8'h01);
    c(4);
    $display("trigger test done");
    so(3'h2,2'h1);
    b=2+$urandom%2;
    so(3'h2,b[1:0]);
    k(own,8'h02);
    k(er,8'h01);
    so(3'h0,2'h1);
    so(3'h2,b[1:0]);
    k(own,8'h01<<b);
    go(10'h100);
    k(er,8'h00);
    pw=1;
    c(2);
    k(t,8'h6E);
    pw=0;
    $display("ext test done");
    go(10'h200);
    k(ac,8'h05);
    k(co,8'h01);
    go(10'h080);
    k(q,8'h04);
    k(ac,8'h01);
    k(co,8'h00);
    k(lv,8'h00);
    k(cc,8'h00);
    k(ar,8'h00);
    go(10'h002);
    go(10'h004);
    c(12);
    k(ch,8'h03);
    $display("reset test done");
    end_of_test;
  end
endmodule // test_scan_trigger_source_control
